// ==== hdl/sas_regs.vh ====
`ifndef SAS_REGS_VH
`define SAS_REGS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define SAS_ADDR_OPTION 8'h94
`define SAS_ADDR_FLAGS 8'h95
`define SAS_ADDR_RES_LO 8'hAA
`define SAS_ADDR_RES_HI 8'hAB
`define SAS_ADDR_CHANNEL_AND_REFERENCE_SELECT 8'hAE
`define SAS_ADDR_AUX 8'hF8

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SAS_OPT_DIV_HI 3
`define SAS_OPT_DIV_LO 2
`define SAS_FLG_DONE 4
`define SAS_AUX_FORCE 5
`define SAS_AUX_START 4
`define SAS_CH_LOW_HI 7
`define SAS_CH_LOW_LO 4
`define SAS_CH_TOP 3
`define SAS_CH_REF 2
`define SAS_CH_LVL_HI 1
`define SAS_CH_LVL_LO 0
`define SAS_CHANNEL_AND_REFERENCE_SELECT_RST 8'hF0
`define SAS_DIV_RST 2'h0

// ----------------------------------------------------------------
// divider terminal counts (divide by 32, 16, 8, 4)
// ----------------------------------------------------------------
`define SAS_DIV_SEL_32 2'h0
`define SAS_DIV_SEL_16 2'h1
`define SAS_DIV_SEL_8 2'h2
`define SAS_DIV_TERM_32 5'h1F
`define SAS_DIV_TERM_16 5'h0F
`define SAS_DIV_TERM_8 5'h07
`define SAS_DIV_TERM_4 5'h03

// ----------------------------------------------------------------
// conversion timing in converter clocks
// ----------------------------------------------------------------
`define SAS_CONV_LAST 6'h31
`define SAS_SH_CLKS 6'h1A
`define SAS_RES_BITS 12
`define SAS_RES_HI_MSB 11
`define SAS_RES_HI_LSB 4
`define SAS_RES_LO_MSB 3

// ----------------------------------------------------------------
// channel codes and reference settings
// ----------------------------------------------------------------
`define SAS_CH_EXT_LO_MAX 5'h0B
`define SAS_CH_BANDGAP 5'h0C
`define SAS_CH_GROUND 5'h0E
`define SAS_CH_QUARTER 5'h0F
`define SAS_CH_EXT_HI_MIN 5'h10
`define SAS_CH_EXT_HI_MAX 5'h16
`define SAS_REF_BANDGAP 1'h1
`define SAS_BG_LEVEL_254 2'h1

`endif

// ==== hdl/sas_clk_div.v ====
`timescale 1ns/1ps
`include "sas_regs.vh"

module sas_clk_div (
	input wire ref_clk,
	input wire rst_n,
	input wire run,
	input wire [1:0] div_sel,
	output reg conv_tick_reg
);

reg [4:0] cnt_reg;
reg [4:0] term;

// ----------------------------------------------------------------
// divide select decode
// ----------------------------------------------------------------
always @* begin
	case (div_sel)
		`SAS_DIV_SEL_32: term = `SAS_DIV_TERM_32;
		`SAS_DIV_SEL_16: term = `SAS_DIV_TERM_16;
		`SAS_DIV_SEL_8: term = `SAS_DIV_TERM_8;
		default: term = `SAS_DIV_TERM_4;
	endcase
end

// ----------------------------------------------------------------
// counter, one tick per converter clock period
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		cnt_reg <= 5'h00;
		conv_tick_reg <= 1'b0;
	end else if (!run) begin
		cnt_reg <= 5'h00;
		conv_tick_reg <= 1'b0;
	end else if (cnt_reg >= term) begin
		cnt_reg <= 5'h00;
		conv_tick_reg <= 1'b1;
	end else begin
		cnt_reg <= cnt_reg + 5'h01;
		conv_tick_reg <= 1'b0;
	end
end

endmodule

// ==== hdl/sas_sar_core.v ====
`timescale 1ns/1ps
`include "sas_regs.vh"

module sas_sar_core (
	input wire ref_clk,
	input wire rst_n,
	input wire start,
	input wire abort,
	input wire tick,
	input wire cmp_high,
	output reg busy_reg,
	output reg done_reg,
	output reg sample_hold_reg,
	output reg [11:0] trial_reg,
	output reg [11:0] result_reg
);

reg [5:0] cnt_reg;
wire [5:0] phase;
wire [3:0] step;
wire in_sar;
wire [11:0] trial_next;

assign phase = cnt_reg - `SAS_SH_CLKS;
assign step = phase[4:1];
assign in_sar = busy_reg && tick && (cnt_reg >= `SAS_SH_CLKS);

// ----------------------------------------------------------------
// two converter clocks per bit: set trial, then keep or drop
// ----------------------------------------------------------------
genvar i;
generate
	for (i = 0; i < `SAS_RES_BITS; i = i + 1) begin : g_bit
		localparam integer STEP_I = `SAS_RES_BITS - 1 - i;
		assign trial_next[i] = (in_sar && step == STEP_I[3:0]) ?
			(phase[0] ? (trial_reg[i] & cmp_high) : 1'b1) : trial_reg[i];
	end
endgenerate

// ----------------------------------------------------------------
// sequence: sample and hold, twelve bit steps, completion
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		busy_reg <= 1'b0;
		done_reg <= 1'b0;
		sample_hold_reg <= 1'b0;
		cnt_reg <= 6'h00;
		trial_reg <= 12'h000;
		result_reg <= 12'h000;
	end else begin
		done_reg <= 1'b0;
		if (start) begin
			busy_reg <= 1'b1;
			sample_hold_reg <= 1'b1;
			cnt_reg <= 6'h00;
			trial_reg <= 12'h000;
		end else if (abort) begin
			busy_reg <= 1'b0;
			sample_hold_reg <= 1'b0;
		end else if (busy_reg && tick) begin
			trial_reg <= trial_next;
			cnt_reg <= cnt_reg + 6'h01;
			if (cnt_reg == `SAS_SH_CLKS - 6'h01) begin
				sample_hold_reg <= 1'b0;
			end
			if (cnt_reg == `SAS_CONV_LAST) begin
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
				result_reg <= trial_next;
			end
		end
	end
end

endmodule

// ==== hdl/sas_top.v ====
// What this block does
// - converter clock is system clock /32,/16,/8,/4
// - start bit begins conversion, cleared at end
// - done flag set, interrupt raised when enabled
// - done flag cleared by EFh or start
// - writing zero clears the start bit
// - conversion lasts fifty converter clocks in total
// - result loaded when done flag sets
// - high byte bits 11-4, low nibble bits 3-0
// - five-bit channel code: top bit plus field
// - channel code map with internal and reserved codes
// - bandgap force bit keeps generator on, except in low power mode
`timescale 1ns/1ps
`include "sas_regs.vh"

module sas_top (
	input wire ref_clk,
	input wire rst_n,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata_reg,
	input wire conv_int_enable,
	input wire low_power_mode,
	input wire cmp_in,
	output reg conv_irq_reg,
	output reg [4:0] mux_code_reg,
	output reg mux_external_reg,
	output reg mux_bandgap_reg,
	output reg mux_ground_reg,
	output reg mux_quarter_reg,
	output reg ref_bandgap_reg,
	output reg [1:0] bandgap_level_reg,
	output reg bandgap_enable_reg,
	output wire sample_hold,
	output wire [11:0] dac_code
);

// ----------------------------------------------------------------
// software-visible state and comparator synchronizer
// ----------------------------------------------------------------
reg [1:0] div_sel_reg;
reg done_flag_reg;
reg start_bit_reg;
reg force_bg_reg;
reg [7:0] channel_and_reference_select_reg;
reg cmp_meta_reg;
reg cmp_sync_reg;
reg [7:0] result_high_byte_reg;
reg [3:0] result_low_nibble_reg;

// ----------------------------------------------------------------
// sequencer connections
// ----------------------------------------------------------------
wire conv_tick;
wire busy;
wire done;
wire [11:0] result;
wire wr_option;
wire wr_flags;
wire wr_channel_and_reference_select;
wire wr_aux;
wire sw_start;
wire sw_stop;
wire div_run;
wire [4:0] code_next;
reg [7:0] rdata_next;
reg [4:0] mux_code_next;
reg ext_next;
reg bg_sel_next;
reg gnd_next;
reg quarter_next;
reg bg_en_next;

// ----------------------------------------------------------------
// write decode
// ----------------------------------------------------------------
assign wr_option = sfr_wr && (sfr_addr == `SAS_ADDR_OPTION);
assign wr_flags = sfr_wr && (sfr_addr == `SAS_ADDR_FLAGS);
assign wr_channel_and_reference_select = sfr_wr && (sfr_addr == `SAS_ADDR_CHANNEL_AND_REFERENCE_SELECT);
assign wr_aux = sfr_wr && (sfr_addr == `SAS_ADDR_AUX);
assign sw_start = wr_aux && sfr_wdata[`SAS_AUX_START];
assign sw_stop = wr_aux && !sfr_wdata[`SAS_AUX_START];

// ----------------------------------------------------------------
// comparator input from the analog side
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		cmp_meta_reg <= 1'b0;
		cmp_sync_reg <= 1'b0;
	end else begin
		cmp_meta_reg <= cmp_in;
		cmp_sync_reg <= cmp_meta_reg;
	end
end

// ----------------------------------------------------------------
// a restart also restarts the converter clock phase
// ----------------------------------------------------------------
assign div_run = busy && !sw_start;

// ----------------------------------------------------------------
// converter clock and approximation sequence
// ----------------------------------------------------------------
sas_clk_div u_clk_div (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.run(div_run),
	.div_sel(div_sel_reg),
	.conv_tick_reg(conv_tick)
);

sas_sar_core u_sar_core (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.start(sw_start),
	.abort(sw_stop),
	.tick(conv_tick),
	.cmp_high(cmp_sync_reg),
	.busy_reg(busy),
	.done_reg(done),
	.sample_hold_reg(sample_hold),
	.trial_reg(dac_code),
	.result_reg(result)
);

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		div_sel_reg <= `SAS_DIV_RST;
		channel_and_reference_select_reg <= `SAS_CHANNEL_AND_REFERENCE_SELECT_RST;
		force_bg_reg <= 1'b0;
	end else begin
		if (wr_option) begin
			div_sel_reg <= sfr_wdata[`SAS_OPT_DIV_HI:`SAS_OPT_DIV_LO];
		end
		if (wr_channel_and_reference_select) begin
			channel_and_reference_select_reg <= sfr_wdata;
		end
		if (wr_aux) begin
			force_bg_reg <= sfr_wdata[`SAS_AUX_FORCE];
		end
	end
end

// ----------------------------------------------------------------
// start bit and done flag
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		start_bit_reg <= 1'b0;
		done_flag_reg <= 1'b0;
	end else begin
		if (sw_start) begin
			start_bit_reg <= 1'b1;
		end else if (sw_stop || done) begin
			start_bit_reg <= 1'b0;
		end
		if (done) begin
			done_flag_reg <= 1'b1;
		end else if (sw_start) begin
			done_flag_reg <= 1'b0;
		end else if (wr_flags && !sfr_wdata[`SAS_FLG_DONE]) begin
			done_flag_reg <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// result bytes, loaded with the done flag
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		result_high_byte_reg <= 8'h00;
		result_low_nibble_reg <= 4'h0;
	end else if (done) begin
		result_high_byte_reg <= result[`SAS_RES_HI_MSB:`SAS_RES_HI_LSB];
		result_low_nibble_reg <= result[`SAS_RES_LO_MSB:0];
	end
end

// ----------------------------------------------------------------
// interrupt request
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		conv_irq_reg <= 1'b0;
	end else begin
		conv_irq_reg <= done_flag_reg && conv_int_enable;
	end
end

// ----------------------------------------------------------------
// channel decode
// ----------------------------------------------------------------
assign code_next = {channel_and_reference_select_reg[`SAS_CH_TOP], channel_and_reference_select_reg[`SAS_CH_LOW_HI:`SAS_CH_LOW_LO]};

always @* begin
	mux_code_next = code_next;
	ext_next = 1'b0;
	bg_sel_next = 1'b0;
	gnd_next = 1'b0;
	quarter_next = 1'b0;
	if (code_next <= `SAS_CH_EXT_LO_MAX) begin
		ext_next = 1'b1;
	end else if (code_next >= `SAS_CH_EXT_HI_MIN && code_next <= `SAS_CH_EXT_HI_MAX) begin
		ext_next = 1'b1;
	end else if (code_next == `SAS_CH_BANDGAP) begin
		bg_sel_next = 1'b1;
	end else if (code_next == `SAS_CH_GROUND) begin
		gnd_next = 1'b1;
	end else if (code_next == `SAS_CH_QUARTER) begin
		quarter_next = 1'b1;
	end
end

// ----------------------------------------------------------------
// bandgap generator enable
// ----------------------------------------------------------------
always @* begin
	bg_en_next = 1'b0;
	if (low_power_mode) begin
		bg_en_next = 1'b0;
	end else if (force_bg_reg) begin
		bg_en_next = 1'b1;
	end else begin
		bg_en_next = busy && (bg_sel_next ||
			(channel_and_reference_select_reg[`SAS_CH_REF] == `SAS_REF_BANDGAP));
	end
end

// ----------------------------------------------------------------
// analog steering outputs
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		mux_code_reg <= 5'h00;
		mux_external_reg <= 1'b0;
		mux_bandgap_reg <= 1'b0;
		mux_ground_reg <= 1'b0;
		mux_quarter_reg <= 1'b0;
		ref_bandgap_reg <= 1'b0;
		bandgap_level_reg <= 2'h0;
		bandgap_enable_reg <= 1'b0;
	end else begin
		mux_code_reg <= mux_code_next;
		mux_external_reg <= ext_next;
		mux_bandgap_reg <= bg_sel_next;
		mux_ground_reg <= gnd_next;
		mux_quarter_reg <= quarter_next;
		ref_bandgap_reg <= channel_and_reference_select_reg[`SAS_CH_REF];
		bandgap_level_reg <= channel_and_reference_select_reg[`SAS_CH_LVL_HI:`SAS_CH_LVL_LO];
		bandgap_enable_reg <= bg_en_next;
	end
end

// ----------------------------------------------------------------
// read data, one cycle after the read strobe
// ----------------------------------------------------------------
always @* begin
	rdata_next = 8'h00;
	if (sfr_rd) begin
		case (sfr_addr)
			`SAS_ADDR_OPTION: begin
				rdata_next[`SAS_OPT_DIV_HI:`SAS_OPT_DIV_LO] = div_sel_reg;
			end
			`SAS_ADDR_FLAGS: begin
				rdata_next[`SAS_FLG_DONE] = done_flag_reg;
			end
			`SAS_ADDR_RES_LO: begin
				rdata_next = {result_low_nibble_reg, 4'h0};
			end
			`SAS_ADDR_RES_HI: begin
				rdata_next = result_high_byte_reg;
			end
			`SAS_ADDR_CHANNEL_AND_REFERENCE_SELECT: begin
				rdata_next = channel_and_reference_select_reg;
			end
			`SAS_ADDR_AUX: begin
				rdata_next[`SAS_AUX_FORCE] = force_bg_reg;
				rdata_next[`SAS_AUX_START] = start_bit_reg;
			end
			default: begin
				rdata_next = 8'h00;
			end
		endcase
	end
end

always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		sfr_rdata_reg <= 8'h00;
	end else begin
		sfr_rdata_reg <= rdata_next;
	end
end

endmodule

// ==== dv/sas_analog_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// comparator seen through the channel mux
// ----------------------------------------
module sas_analog_model (
	input wire [4:0] mux_code,
	input wire [11:0] dac_code,
	output wire cmp_in
);
	// every channel code gives its own level, so a wrong mux shows in the result
	wire [11:0] level = {mux_code, 7'h35};
	assign cmp_in = level >= dac_code;
endmodule

// ==== dv/sas_top_chk.sv ====
`timescale 1ns/1ps
module sas_chk (
	input wire ref_clk,
	input wire rst_n,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata_reg,
	input wire conv_int_enable,
	input wire low_power_mode,
	input wire conv_irq_reg,
	input wire [4:0] mux_code_reg,
	input wire mux_external_reg,
	input wire mux_bandgap_reg,
	input wire mux_ground_reg,
	input wire mux_quarter_reg,
	input wire bandgap_enable_reg,
	input wire sample_hold
);
	// ----------------------------------------
	// register strobes and properties
	// ----------------------------------------
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	wire w_aux = sfr_wr && sfr_addr == 8'hF8;
	wire w_flg = sfr_wr && sfr_addr == 8'h95 && !sfr_wdata[4];
	wire [4:0] c = mux_code_reg;
	a_low_nibble_zero: assert property (
		$past(sfr_rd && sfr_addr == 8'hAA) |-> sfr_rdata_reg[3:0] == 4'h0)
		else $error("low result nibble not zero");
	a_external_decode: assert property (
		$past(rst_n) |-> mux_external_reg == (c <= 5'h0B || (c >= 5'h10 && c <= 5'h16)))
		else $error("external input decode wrong");
	a_internal_decode: assert property (
		$past(rst_n) |-> {mux_bandgap_reg, mux_ground_reg, mux_quarter_reg} ==
		{c == 5'h0C, c == 5'h0E, c == 5'h0F})
		else $error("internal source decode wrong");
	a_irq_needs_enable: assert property (
		conv_irq_reg |-> $past(conv_int_enable))
		else $error("request raised while disabled");
	a_flag_write_clear: assert property (
		w_flg |=> ##1 !conv_irq_reg)
		else $error("flag write did not clear request");
	a_start_clears_flag: assert property (
		w_aux && sfr_wdata[4] |=> ##1 !conv_irq_reg)
		else $error("start did not clear request");
	a_start_samples: assert property (
		w_aux && sfr_wdata[4] |=> sample_hold[*8])
		else $error("start did not begin sampling");
	a_abort_stops: assert property (
		w_aux && !sfr_wdata[4] |=> !sample_hold)
		else $error("abort left sampling on");
	a_low_power_off: assert property (
		low_power_mode |=> !bandgap_enable_reg)
		else $error("bandgap on in low power");
endmodule

bind sas_top sas_chk chk (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
	.sfr_rdata_reg, .conv_int_enable, .low_power_mode, .conv_irq_reg, .mux_code_reg,
	.mux_external_reg, .mux_bandgap_reg, .mux_ground_reg, .mux_quarter_reg,
	.bandgap_enable_reg, .sample_hold);

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, conv_int_enable = 0;
	logic low_power_mode = 0, cmp_in, conv_irq_reg, mux_external_reg, mux_bandgap_reg;
	logic mux_ground_reg, mux_quarter_reg, ref_bandgap_reg, bandgap_enable_reg, sample_hold;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_reg, rv;
	logic [4:0] mux_code_reg;
	logic [1:0] bandgap_level_reg;
	logic [11:0] dac_code;
	logic [4:0] chs[4] = '{5'h00, 5'h0B, 5'h10, 5'h16};
	logic [4:0] cs[5] = '{5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h17};
	logic [3:0] de[5] = '{4'h4, 4'h0, 4'h2, 4'h1, 4'h0};
	int num_errors = 0, checks = 0, cyc = 0;
	always #12.5 ref_clk = ~ref_clk;
	sas_top dut (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_reg,
		.conv_int_enable, .low_power_mode, .cmp_in, .conv_irq_reg, .mux_code_reg,
		.mux_external_reg, .mux_bandgap_reg, .mux_ground_reg, .mux_quarter_reg,
		.ref_bandgap_reg, .bandgap_level_reg, .bandgap_enable_reg, .sample_hold, .dac_code);
	sas_analog_model ain (.mux_code(mux_code_reg), .dac_code, .cmp_in);
	// ----------------------------------------
	// bus cycles, compare and closing
	// ----------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test;
		if (num_errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1;
		@(negedge ref_clk);
		sfr_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_rd = 1;
		@(negedge ref_clk);
		sfr_rd = 0;
		rv = sfr_rdata_reg;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			finish_test;
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [7:0] ra[5] = '{8'hAE, 8'h94, 8'h95, 8'hF8, 8'h10};
		wr(8'h10, 8'hFF);
		foreach (ra[i]) begin
			rd(ra[i]);
			check(rv, (i == 0) ? 8'hF0 : 8'h00, "reset read");
		end
	endtask
	task automatic t_mux;
		foreach (cs[i]) begin
			wr(8'hAE, {cs[i][3:0], cs[i][4], 3'h0});
			idle(1);
			check({mux_code_reg, mux_external_reg, mux_bandgap_reg, mux_ground_reg,
				mux_quarter_reg}, {cs[i], de[i]}, "mux");
		end
	endtask
	task automatic t_conv;
		int n;
		conv_int_enable = 1;
		for (int i = 0; i < 4; i++) begin
			// every divider code runs; the speed limit concerns the analog part only
			wr(8'h94, {4'h0, i[1:0], 2'h0});
			wr(8'hAE, {chs[i][3:0], chs[i][4], 3'h0});
			wr(8'hF8, 8'h10);
			n = 0;
			while (conv_irq_reg !== 1'b1 && n < 3000) begin
				@(negedge ref_clk);
				n++;
			end
			check(n >= 50 * (32 >> i) && n <= 50 * (32 >> i) + 6, 1, "duration");
			rd(8'hAB);
			check(rv, {chs[i], 3'h3}, "result high");
			rd(8'hAA);
			check(rv, 8'h50, "result low");
			rd(8'hF8);
			check(rv, 8'h00, "start bit");
			rd(8'h95);
			check(rv, 8'h10, "done flag");
			wr(8'h95, 8'hEF);
			idle(1);
			check(conv_irq_reg, 0, "cleared irq");
		end
	endtask
	task automatic t_mask;
		conv_int_enable = 0;
		wr(8'hF8, 8'h10);
		idle(220);
		check(conv_irq_reg, 0, "masked irq");
		rd(8'h95);
		check(rv, 8'h10, "masked flag");
		conv_int_enable = 1;
		idle(2);
		check(conv_irq_reg, 1, "unmasked irq");
		wr(8'hAE, 8'h00);
		wr(8'hF8, 8'h10);
		rd(8'h95);
		check(rv, 8'h00, "flag after start");
		rd(8'hF8);
		check(rv, 8'h10, "busy start bit");
		idle(40);
		wr(8'hF8, 8'h00);
		idle(250);
		check(conv_irq_reg, 0, "irq after abort");
		rd(8'hF8);
		check(rv, 8'h00, "aborted start bit");
		rd(8'hAB);
		check(rv, 8'hB3, "held result");
	endtask
	task automatic t_bgap;
		int n;
		// bandgap reference selected here with the 01 level code; the design sets the two fields independently
		wr(8'hAE, 8'h05);
		wr(8'hF8, 8'h20);
		idle(1);
		check({ref_bandgap_reg, bandgap_level_reg, bandgap_enable_reg}, 4'hB, "forced");
		low_power_mode = 1;
		idle(2);
		check(bandgap_enable_reg, 0, "low power bandgap");
		low_power_mode = 0;
		wr(8'hF8, 8'h00);
		idle(1);
		check(bandgap_enable_reg, 0, "auto idle bandgap");
		wr(8'hF8, 8'h10);
		idle(1);
		check(bandgap_enable_reg, 1, "auto busy bandgap");
		idle(20);
		wr(8'hF8, 8'h10);
		n = 0;
		while (conv_irq_reg !== 1'b1 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		check(n >= 50 * 4 && n <= 50 * 4 + 6, 1, "restart duration");
		check(bandgap_enable_reg, 0, "auto done bandgap");
		rd(8'hAB);
		check(rv, 8'h03, "restart result");
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1;
		t_reset;
		t_mux;
		t_conv;
		t_mask;
		t_bgap;
		finish_test;
	end
endmodule
